// ---- hdl/aux_pin_consts.svh ----
`ifndef AUX_PIN_CONSTS_SVH
`define AUX_PIN_CONSTS_SVH
// register byte offsets on the bus
`define AUX_OFS_DIR       8'h00
`define AUX_OFS_IN        8'h04
`define AUX_OFS_OUT       8'h08
`define AUX_OFS_DRIVE     8'h0c
`define AUX_OFS_FUNC      8'h10
`define AUX_OFS_ISTAT     8'h14
`define AUX_OFS_IMASK     8'h18
`define AUX_OFS_CHAN      8'h1c
// reset values
`define AUX_RST_DIR       8'hff
`define AUX_RST_OUT       8'h00
`define AUX_RST_DRIVE     8'h00
`define AUX_RST_FUNC      6'h00
`define AUX_RST_ISTAT     2'h0
`define AUX_RST_IMASK     2'h3
// function register bit positions
`define AUX_FN_PIN5SEL    0
`define AUX_FN_CLKSRC     1
`define AUX_FN_TRIGA      2
`define AUX_FN_TRIGB      3
`define AUX_FN_PIN7SG     4
`define AUX_FN_PIN4MB     5
`define AUX_FN_W          6
// pin numbers with special duties
`define AUX_PIN_MULTIFRAME_BIT_PIN      4
`define AUX_PIN_CLK       5
`define AUX_PIN_IRQA      6
`define AUX_PIN_IRQB      7
// highest channel usable with the slow data clock
`define AUX_CHAN_SLOW_MAX 3'h2
`endif

// ---- hdl/aux_pin_controller.sv ----
`timescale 1ns/1ps
`include "aux_pin_consts.svh"

// Functional notes
// - all pins are inputs after reset
// - mode picks gpio or channel-strap pins 0-2
// - direction bit 1 input, read samples level
// - output register drives output pins promptly
// - drive bit 0 open drain, 1 push-pull
// - input read returns real level of outputs
// - pin5 function bit selects clock output
// - clock source bit picks sync or bit clock
// - pins 6,7 gpio, interrupts masked after reset
// - input pins 6,7 set masked status bits
// - each interrupt input edge or level triggered
// - pull-up on 6,7 unless push-pull output
// - pin7 select bit outputs stop/go bit
// - pin4 select bit gives multiframe bit use
// - multiframe pin direction follows operating mode
// - three straps form binary channel number
// - slow data clock allows channels 0-2 only
// - channel number offsets serial timeslot choices
// - frame carries up to eight channels
module aux_pin_controller
  import aux_pin_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire aux_pin_pkg::wbReq_type wbReq,
  output logic                        wbAck,
  output logic [31:0]                 wbDatO,
  input  wire aux_pin_pkg::opMode_type opMode,
  input  wire logic [7:0]             padIn,
  output aux_pin_pkg::padOut_type     padOut,
  output logic [1:0]                  pullUpEn,
  input  wire logic                   serialDataClock,
  input  wire logic                   frameSync,
  input  wire logic                   dataClockFast,
  input  wire logic                   stopGoBit,
  input  wire logic                   mbitTx,
  output logic                        mbitRx,
  output logic [2:0]                  chanSel,
  output logic                        chanBad,
  output logic                        irq
);
  import aux_pin_pkg::*;

  // whole module state
  typedef struct packed {
    logic [7:0]           dir;
    logic [7:0]           outv;
    logic [7:0]           drv;
    logic [`AUX_FN_W-1:0] func;
    logic [1:0]           stat;
    logic [1:0]           mask;
    logic [7:0]           pinS1;
    logic [7:0]           pinS2;
    logic [1:0]           irqPrev;
    logic                 dclS1;
    logic                 dclS2;
    logic                 dclPrev;
    logic                 fsS1;
    logic                 fsS2;
    logic                 bitClk;
    logic [7:0]           padO;
    logic [7:0]           padOe;
    logic [1:0]           pull;
    logic                 mbitIn;
    logic [2:0]           chan;
    logic                 chanErr;
    logic                 irqOut;
    logic                 ack;
    logic [31:0]          rdat;
  } state_type;

  // registered state and the value it takes at the next edge
  state_type s_q;
  state_type s_d;

  // per-cycle helpers, all given a value at the top of the comb process
  logic       access;
  logic       wrEn;
  logic [7:0] wdat;
  logic [1:0] irqSet;
  logic [1:0] irqClr;
  logic [1:0] irqLvl;
  logic [1:0] drvPair;
  logic       strapMode;
  logic       mbitOutMode;
  logic       clkOut;

  // address match for one register
  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction : hit

  // pad output and enable for a gpio pin: {oe, o}
  function automatic logic [1:0] padDrive(input logic isIn,
                                          input logic val,
                                          input logic pushPull);
    logic [1:0] r;
    r = 2'h0;
    if (!isIn) begin
      if (pushPull) begin
        r = {1'b1, val};
      end else begin
        // open drain only pulls low, high is left to pull-ups
        r = {~val, 1'b0};
      end
    end
    padDrive = r;
  endfunction : padDrive

  // pull-up wanted on an interrupt pin: input or open-drain output
  function automatic logic pullWanted(input logic isIn,
                                      input logic pushPull);
    pullWanted = isIn | ~pushPull;
  endfunction : pullWanted

  // the pin 6/7 slices assume neighbouring interrupt pins; a moved
  // constant would scramble the status bits, so refuse it early
  if (`AUX_PIN_IRQB != `AUX_PIN_IRQA + 1) begin : g_irq_pins_bad
    $error("interrupt pins must be neighbours");
  end
  // every select bit must lie inside the function field
  if (`AUX_FN_PIN4MB >= `AUX_FN_W) begin : g_fn_width_bad
    $error("function field narrower than its select bits");
  end
  // the interrupt pins must be among the eight pads
  if (`AUX_PIN_IRQB > 7) begin : g_pin_range_bad
    $error("special pin number beyond the pad count");
  end

  // next-state logic
  always_comb begin
    // start from the held state, helpers cleared
    s_d = s_q;
    access = wbReq.cyc & wbReq.stb & ~s_q.ack;
    wrEn = access & wbReq.we & wbReq.sel[0];
    wdat = wbReq.dat[7:0];
    irqSet = 2'h0;
    irqClr = 2'h0;
    irqLvl = 2'h0;
    drvPair = 2'h0;
    strapMode = 1'b0;
    mbitOutMode = 1'b0;
    clkOut = 1'b0;

    // pin and clock synchronisers
    s_d.pinS1 = padIn;
    s_d.pinS2 = s_q.pinS1;
    s_d.dclS1 = serialDataClock;
    s_d.dclS2 = s_q.dclS1;
    s_d.dclPrev = s_q.dclS2;
    s_d.fsS1 = frameSync;
    s_d.fsS2 = s_q.fsS1;

    // bit clock is the data clock halved, taken on its rising edges
    if (s_q.dclS2 && !s_q.dclPrev) begin
      s_d.bitClk = ~s_q.bitClk;
    end
    // source select: 0 frame sync, 1 bit clock
    if (s_q.func[`AUX_FN_CLKSRC]) begin
      clkOut = s_q.bitClk;
    end else begin
      clkOut = s_q.fsS2;
    end

    // mode decode
    case (opMode)
      MODE_TE: begin
        strapMode = 1'b0;
        mbitOutMode = 1'b1;
      end
      MODE_LTT: begin
        strapMode = 1'b1;
        mbitOutMode = 1'b1;
      end
      MODE_LTS: begin
        strapMode = 1'b1;
        mbitOutMode = 1'b0;
      end
      MODE_NT: begin
        strapMode = 1'b1;
        mbitOutMode = 1'b0;
      end
      MODE_INTNT: begin
        strapMode = 1'b0;
        mbitOutMode = 1'b0;
      end
      default: begin
        // unknown code: behave as the gpio-only mode, no outputs forced
        strapMode = 1'b0;
        mbitOutMode = 1'b0;
      end
    endcase

    // general pin drive from the software registers
    for (int i = 0; i < 8; i++) begin
      drvPair = padDrive(s_q.dir[i], s_q.outv[i], s_q.drv[i]);
      s_d.padOe[i] = drvPair[1];
      s_d.padO[i] = drvPair[0];
    end

    // strap pins are inputs whatever the registers say
    if (strapMode) begin
      s_d.padOe[2:0] = 3'h0;
      s_d.padO[2:0] = 3'h0;
    end

    // multiframe bit overrides the gpio setup of pin 4
    s_d.mbitIn = 1'b0;
    if (s_q.func[`AUX_FN_PIN4MB]) begin
      if (mbitOutMode) begin
        s_d.padOe[`AUX_PIN_MULTIFRAME_BIT_PIN] = 1'b1;
        s_d.padO[`AUX_PIN_MULTIFRAME_BIT_PIN] = mbitTx;
      end else begin
        s_d.padOe[`AUX_PIN_MULTIFRAME_BIT_PIN] = 1'b0;
        s_d.padO[`AUX_PIN_MULTIFRAME_BIT_PIN] = 1'b0;
        s_d.mbitIn = s_q.pinS2[`AUX_PIN_MULTIFRAME_BIT_PIN];
      end
    end

    // clock-derived output on pin 5, driven push-pull
    if (s_q.func[`AUX_FN_PIN5SEL]) begin
      s_d.padOe[`AUX_PIN_CLK] = 1'b1;
      s_d.padO[`AUX_PIN_CLK] = clkOut;
    end

    // stop/go bit on pin 7, driven push-pull
    if (s_q.func[`AUX_FN_PIN7SG]) begin
      s_d.padOe[`AUX_PIN_IRQB] = 1'b1;
      s_d.padO[`AUX_PIN_IRQB] = stopGoBit;
    end

    // pull-ups on pins 6 and 7 off only for push-pull drive
    s_d.pull[0] = pullWanted(s_q.dir[`AUX_PIN_IRQA],
                             s_q.drv[`AUX_PIN_IRQA]);
    // stop/go use drives pin 7 push-pull, so its pull-up goes off too
    s_d.pull[1] = pullWanted(s_q.dir[`AUX_PIN_IRQB],
                             s_q.drv[`AUX_PIN_IRQB]) &
                  ~s_q.func[`AUX_FN_PIN7SG];

    // interrupt inputs: active low, edge mode on the falling edge
    irqLvl = s_q.pinS2[`AUX_PIN_IRQB:`AUX_PIN_IRQA];
    s_d.irqPrev = irqLvl;
    for (int k = 0; k < 2; k++) begin
      if (s_q.func[`AUX_FN_TRIGA + k]) begin
        irqSet[k] = ~irqLvl[k];
      end else begin
        irqSet[k] = s_q.irqPrev[k] & ~irqLvl[k];
      end
    end
    // only a pin set as input may raise its flag
    irqSet[0] = irqSet[0] & s_q.dir[`AUX_PIN_IRQA];
    // pin 7 carrying stop/go is an output whatever its direction bit
    irqSet[1] = irqSet[1] & s_q.dir[`AUX_PIN_IRQB] &
                ~s_q.func[`AUX_FN_PIN7SG];

    // strapped channel number, bit 2 most significant
    if (strapMode) begin
      s_d.chan = s_q.pinS2[2:0];
    end else begin
      s_d.chan = 3'h0;
    end
    // eight channels per frame, but the slow clock carries three
    s_d.chanErr = strapMode & ~dataClockFast &
                  (s_q.pinS2[2:0] > `AUX_CHAN_SLOW_MAX);

    // register writes
    if (wrEn) begin
      if (hit(wbReq.adr, `AUX_OFS_DIR)) begin
        s_d.dir = wdat;
      end
      if (hit(wbReq.adr, `AUX_OFS_OUT)) begin
        s_d.outv = wdat;
      end
      if (hit(wbReq.adr, `AUX_OFS_DRIVE)) begin
        s_d.drv = wdat;
      end
      if (hit(wbReq.adr, `AUX_OFS_FUNC)) begin
        s_d.func = wdat[`AUX_FN_W-1:0];
      end
      if (hit(wbReq.adr, `AUX_OFS_ISTAT)) begin
        irqClr = wdat[1:0];
      end
      if (hit(wbReq.adr, `AUX_OFS_IMASK)) begin
        s_d.mask = wdat[1:0];
      end
    end

    // sticky status, a new event beats a clear in the same cycle
    s_d.stat = (s_q.stat & ~irqClr) | irqSet;
    // mask bit 1 blocks the interrupt
    s_d.irqOut = |(s_d.stat & ~s_d.mask);

    // bus answer one cycle after the request, then dropped
    s_d.ack = access;
    s_d.rdat = 32'h0;
    if (access && !wbReq.we) begin
      if (hit(wbReq.adr, `AUX_OFS_DIR)) begin
        s_d.rdat[7:0] = s_q.dir;
      end else if (hit(wbReq.adr, `AUX_OFS_IN)) begin
        // real pad level, outputs included
        s_d.rdat[7:0] = s_q.pinS2;
      end else if (hit(wbReq.adr, `AUX_OFS_OUT)) begin
        s_d.rdat[7:0] = s_q.outv;
      end else if (hit(wbReq.adr, `AUX_OFS_DRIVE)) begin
        s_d.rdat[7:0] = s_q.drv;
      end else if (hit(wbReq.adr, `AUX_OFS_FUNC)) begin
        s_d.rdat[`AUX_FN_W-1:0] = s_q.func;
      end else if (hit(wbReq.adr, `AUX_OFS_ISTAT)) begin
        s_d.rdat[1:0] = s_q.stat;
      end else if (hit(wbReq.adr, `AUX_OFS_IMASK)) begin
        s_d.rdat[1:0] = s_q.mask;
      end else if (hit(wbReq.adr, `AUX_OFS_CHAN)) begin
        // timeslot offset handed to the serial-bus registers
        s_d.rdat[3:0] = {s_q.chanErr, s_q.chan};
      end else begin
        s_d.rdat = 32'h0;
      end
    end
  end

  // state register; reset leaves every pin undriven
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // software registers
      s_q.dir     <= `AUX_RST_DIR;
      s_q.outv    <= `AUX_RST_OUT;
      s_q.drv     <= `AUX_RST_DRIVE;
      s_q.func    <= `AUX_RST_FUNC;
      s_q.stat    <= `AUX_RST_ISTAT;
      s_q.mask    <= `AUX_RST_IMASK;

      // pad synchronisers idle at the pulled-up level, clock ones low, no false edge
      s_q.pinS1   <= 8'hff;
      s_q.pinS2   <= 8'hff;
      s_q.irqPrev <= 2'h3;
      s_q.dclS1   <= 1'b0;
      s_q.dclS2   <= 1'b0;
      s_q.dclPrev <= 1'b0;
      s_q.fsS1    <= 1'b0;
      s_q.fsS2    <= 1'b0;
      s_q.bitClk  <= 1'b0;

      // registered outputs
      s_q.padO    <= 8'h00;
      s_q.padOe   <= 8'h00;
      s_q.pull    <= 2'h3;
      s_q.mbitIn  <= 1'b0;
      s_q.chan    <= 3'h0;
      s_q.chanErr <= 1'b0;
      s_q.irqOut  <= 1'b0;
      s_q.ack     <= 1'b0;
      s_q.rdat    <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign wbAck     = s_q.ack;
  assign wbDatO    = s_q.rdat;
  assign padOut.o  = s_q.padO;
  assign padOut.oe = s_q.padOe;
  assign pullUpEn  = s_q.pull;
  assign mbitRx    = s_q.mbitIn;
  assign chanSel   = s_q.chan;
  assign chanBad   = s_q.chanErr;
  assign irq       = s_q.irqOut;
endmodule : aux_pin_controller

// ---- hdl/aux_pin_pkg.sv ----
package aux_pin_pkg;
  // operating mode of the device, one-hot
  typedef enum logic [4:0] {
    MODE_TE    = 5'h01,
    MODE_LTT   = 5'h02,
    MODE_LTS   = 5'h04,
    MODE_NT    = 5'h08,
    MODE_INTNT = 5'h10
  } opMode_type;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wbReq_type;

  // pad signals of the eight auxiliary pins
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } padOut_type;
endpackage : aux_pin_pkg

// ---- tb/aux_pad_model.sv ----
`timescale 1ns/1ps
// board side: outside drivers, pull-ups on pins 6 and 7, wired-and
module aux_pad_model (
  input wire logic                    sys_clk,
  input wire aux_pin_pkg::padOut_type padOut,
  input wire logic [1:0]              pullUpEn,
  input wire logic [7:0]              extEn,
  input wire logic [7:0]              extVal,
  output logic [7:0]                  padIn
);
  import aux_pin_pkg::*;
  logic [7:0] drift = 8'h5a;

  // a pin nobody holds toggles, so no stale level can be read
  always @(posedge sys_clk) drift <= ~padIn;
  // low wins, then any high driver, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if ((padOut.oe[i] && !padOut.o[i]) || (extEn[i] && !extVal[i]))
        padIn[i] = 1'b0;
      else if (padOut.oe[i] || extEn[i] || (i > 5 && pullUpEn[i[0]]))
        padIn[i] = 1'b1;
      else
        padIn[i] = drift[i];
    end
  end
endmodule : aux_pad_model

// ---- tb/aux_pin_controller_properties.sv ----
`timescale 1ns/1ps
module aux_pin_checker (
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire aux_pin_pkg::wbReq_type  wbReq,
  input wire logic                    wbAck,
  input wire logic [31:0]             wbDatO,
  input wire aux_pin_pkg::opMode_type opMode,
  input wire logic [7:0]              padIn,
  input wire aux_pin_pkg::padOut_type padOut,
  input wire logic                    dataClockFast,
  input wire logic                    mbitRx,
  input wire logic [2:0]              chanSel,
  input wire logic                    chanBad
);
  import aux_pin_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // bus answer: one cycle, right after the request is taken
  chk_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack held too long");
  chk_ack_next: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
    else $error("request not answered");
  chk_dat_idle: assert property (!wbAck |-> wbDatO == 32'h0)
    else $error("read data outside ack");
  // low pins move only after a write or a mode change
  chk_out_hold: assert property (
    !$past(wbAck) && $past(opMode) == opMode && $past(opMode, 2) == opMode
      |-> $stable(padOut.o[3:0]) && $stable(padOut.oe[3:0]))
    else $error("pins moved without cause");
  // straps settle through the synchroniser within four cycles
  chk_strap_chan: assert property (
    (!(opMode inside {MODE_TE, MODE_INTNT}) && $stable(opMode)
      && $stable(padIn[2:0]))[*4] |-> chanSel == padIn[2:0])
    else $error("channel not from straps");
  chk_chan_off: assert property (
    (opMode inside {MODE_TE, MODE_INTNT} && $stable(opMode))[*2]
      |-> chanSel == 3'h0)
    else $error("channel outside strap modes");
  chk_chan_bad: assert property (
    $stable(chanSel) && $stable(dataClockFast)
      |-> chanBad == (chanSel > 3'h2 && !dataClockFast))
    else $error("channel limit flag wrong");
  chk_multiframe_bit_pin_in: assert property (
    mbitRx && $stable(opMode)
      |-> opMode inside {MODE_LTS, MODE_NT, MODE_INTNT})
    else $error("multiframe input in output mode");
endmodule : aux_pin_checker

bind aux_pin_controller aux_pin_checker chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .wbReq(wbReq), .wbAck(wbAck),
  .wbDatO(wbDatO), .opMode(opMode), .padIn(padIn), .padOut(padOut),
  .dataClockFast(dataClockFast), .mbitRx(mbitRx), .chanSel(chanSel),
  .chanBad(chanBad));

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import aux_pin_pkg::*;
  logic        sys_clk;
  logic        rst_n;
  wbReq_type   req;
  logic        wbAck;
  logic [31:0] wbDatO;
  opMode_type  opMode;
  padOut_type  padOut;
  logic [7:0]  padIn, extEn, extVal, r, v, d, x;
  logic [2:0]  chanSel;
  logic [1:0]  pullUpEn;
  logic        fs, dcf, sg, mtx, serial_data_clock, mbitRx, chanBad, irq;
  int          n_errors = 0;
  int          checked = 0;
  // reset model: offset and content, unmapped 20 last
  logic [15:0] rt[$] = '{16'h00ff, 16'h0800, 16'h0c00, 16'h1000,
                         16'h1400, 16'h1803, 16'h2000};
  opMode_type  mt[4] = '{MODE_LTT, MODE_LTS, MODE_NT, MODE_INTNT};

  aux_pin_controller dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .wbReq(req), .wbAck(wbAck),
    .wbDatO(wbDatO), .opMode(opMode), .padIn(padIn), .padOut(padOut),
    .pullUpEn(pullUpEn), .serialDataClock(serial_data_clock), .frameSync(fs),
    .dataClockFast(dcf), .stopGoBit(sg), .mbitTx(mtx), .mbitRx(mbitRx),
    .chanSel(chanSel), .chanBad(chanBad), .irq(irq));
  aux_pad_model pad_u (.sys_clk(sys_clk), .padOut(padOut),
    .pullUpEn(pullUpEn), .extEn(extEn), .extVal(extVal), .padIn(padIn));

  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] dv,
                    output logic [7:0] rd);
    req <= '{1'b1, 1'b1, w, a, 4'hf, {24'h0, dv}};
    // no cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge sys_clk);
    end while (wbAck !== 1'b1);
    rd = wbDatO[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge sys_clk);
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rdc

  task automatic final_report;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #5000000;
    n_errors++;
    final_report;
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    opMode = MODE_TE;
    extEn = 8'h00;
    extVal = 8'hff;
    {fs, dcf, sg, mtx, serial_data_clock} = 5'h0;
    void'($urandom(904));
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(padOut.oe, 0);
    chk(irq, 0);
    foreach (rt[i]) rdc(rt[i][15:8], rt[i][7:0]);
    // random outputs; pin 3 released and pulled low from outside
    repeat (4) begin
      v = 8'($urandom) | 8'h08;
      d = 8'($urandom) & 8'hf7;
      x = 8'($urandom) & 8'hf7;
      extEn <= ~d & v;
      extVal <= x;
      wb(1'b1, 8'h08, v, r);
      wb(1'b1, 8'h0c, d, r);
      wb(1'b1, 8'h00, 8'h00, r);
      repeat (3) @(posedge sys_clk);
      chk(padOut.oe, 8'(d | ~v));
      chk(padOut.o, d & v);
      chk(pullUpEn, 2'(~d[7:6]));
      rdc(8'h04, v & (d | x));
    end
    // all inputs, levels from outside
    x = 8'($urandom);
    extEn <= 8'hff;
    extVal <= x;
    wb(1'b1, 8'h00, 8'hff, r);
    repeat (3) @(posedge sys_clk);
    rdc(8'h04, x);
    // pin 6 edge then level, pin 7 level and masked
    extVal <= 8'hff;
    wb(1'b1, 8'h18, 8'h00, r);
    repeat (4) @(posedge sys_clk);
    wb(1'b1, 8'h14, 8'h03, r);
    rdc(8'h14, 8'h00);
    extVal <= 8'hbf;
    repeat (5) @(posedge sys_clk);
    chk(irq, 1);
    wb(1'b1, 8'h14, 8'h01, r);
    rdc(8'h14, 8'h00);
    chk(irq, 0);
    wb(1'b1, 8'h10, 8'h0c, r);
    wb(1'b1, 8'h14, 8'h01, r);
    rdc(8'h14, 8'h01);
    extVal <= 8'h7f;
    wb(1'b1, 8'h18, 8'h02, r);
    repeat (4) @(posedge sys_clk);
    wb(1'b1, 8'h14, 8'h03, r);
    rdc(8'h14, 8'h02);
    chk(irq, 0);
    wb(1'b1, 8'h18, 8'h00, r);
    chk(irq, 1);
    // function outputs on pins 4, 5 and 7
    extEn <= 8'h00;
    wb(1'b1, 8'h10, 8'h31, r);
    for (int i = 0; i < 2; i++) begin
      fs <= i[0];
      sg <= !i[0];
      mtx <= i[0];
      repeat (5) @(posedge sys_clk);
      chk(padOut.oe[7:4], 4'hb);
      chk({padOut.o[7], padOut.o[5:4]}, {!i[0], i[0], i[0]});
    end
    // bit clock on pin 5: one output step per rising data clock edge
    wb(1'b1, 8'h10, 8'h33, r);
    for (int i = 1; i < 5; i++) begin
      serial_data_clock <= 1'b1;
      repeat (5) @(posedge sys_clk);
      serial_data_clock <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk(padOut.o[5], i % 2);
    end
    // multiframe pin as input, low pins forced to straps
    wb(1'b1, 8'h00, 8'h00, r);
    opMode <= MODE_LTS;
    extEn <= 8'h10;
    for (int i = 0; i < 2; i++) begin
      extVal <= 8'(i << 4);
      repeat (5) @(posedge sys_clk);
      chk(padOut.oe[4], 0);
      chk(mbitRx, i[0]);
      chk(padOut.oe[2:0], 0);
    end
    // straps in the LTT, LTS, NT and INTNT modes at both data clock rates
    extEn <= 8'h07;
    for (int i = 0; i < 8; i++) begin
      x = 8'($urandom);
      opMode <= mt[i[1:0]];
      dcf <= i[2];
      extVal <= x;
      repeat (5) @(posedge sys_clk);
      d = (i[1:0] == 2'h3) ? 8'h00 : {5'h0, x[2:0]};
      chk(chanSel, d[2:0]);
      chk(chanBad, d > 2 && !i[2]);
      rdc(8'h1c, d | ((d > 2 && !i[2]) ? 8'h08 : 8'h00));
    end
    final_report;
  end
endmodule : tb_top
